// ===== rtl/sc_pkg.sv
// Shared constants, state codes and helpers for the serial configuration link.
// Assumes both ends run on a 100 MHz sys_clk and meet in sc_link_if.
`default_nettype none

package sc_pkg;

  // ==========================================================
  // Clock and counters
  localparam int SYS_MHZ = 100;
  localparam int CNT_W   = 20;

  // ==========================================================
  // Times as printed, and their cycle counts
  localparam int T_CF2ST0_NS      = 600;
  localparam int CF2ST0_CYC       = T_CF2ST0_NS * SYS_MHZ / 1000;
  localparam int T_CFG_US         = 2;
  localparam int CFG_CYC          = T_CFG_US * SYS_MHZ;
  localparam int T_STATUS_MIN_US  = 268;
  localparam int T_STATUS_HI_US   = 3000;
  localparam int T_CF2ST1_HI_US   = 3000;
  localparam int T_ST2CK_US       = 10;
  localparam int ST2CK_CYC        = T_ST2CK_US * SYS_MHZ;
  localparam int T_CF2CK_US       = 3010;
  localparam int T_CD2UM_MIN_US   = 175;
  localparam int T_CD2UM_HI_US    = 830;
  localparam int INIT_MIN_CLKS    = 600;
  localparam int PS_FMAX_MHZ      = 125;
  localparam int CD2CU_PERIODS    = 4;
  localparam int CD2CU_CYC        =
    (CD2CU_PERIODS * SYS_MHZ + PS_FMAX_MHZ - 1) / PS_FMAX_MHZ;
  localparam int OSC_TOP_X10      = 125;
  localparam int UCLK_TOP_MHZ     = 100;
  localparam int HOST_HALF_CYC    = 4;

  // ==========================================================
  // Active serial clock settings, in units of 100 kHz
  localparam int         AS_F0_X10   = 125;
  localparam logic [1:0] OSC_50      = 2'h2;
  localparam logic [1:0] OSC_100     = 2'h3;
  localparam int         CMD_BITS    = 8;
  localparam logic [7:0] AS_READ_CMD = 8'h03;
  localparam logic [2:0] BYTE_LAST   = 3'h7;

  // ==========================================================
  // Synchroniser reset values: request and status idle high
  localparam logic [4:0] DEV_SYNC_RST  = 5'h03;
  localparam logic [3:0] HOST_SYNC_RST = 4'h1;

  // ==========================================================
  // State codes
  typedef enum logic [2:0] {
    D_HOLD = 3'h0,
    D_WAIT = 3'h1,
    D_CFG  = 3'h2,
    D_INIT = 3'h3,
    D_USER = 3'h4
  } sc_dev_state_e;

  typedef enum logic [2:0] {
    H_IDLE = 3'h0,
    H_REQ  = 3'h1,
    H_WAIT = 3'h2,
    H_SEND = 3'h3,
    H_DONE = 3'h4
  } sc_host_state_e;

  // Half period in sys cycles; 100 MHz cannot be made from 100 MHz, so it floors to one
  function automatic int sc_as_half(input logic [1:0] sel);
    int f;
    f = AS_F0_X10 << sel;
    return ((SYS_MHZ * 10) / (2 * f) < 1) ? 1 : (SYS_MHZ * 10) / (2 * f);
  endfunction

endpackage

`default_nettype wire

// ===== rtl/sc_link_if.sv
// Pins between the configuring host (or flash) and the configured device.
// Assumes each end drives only the signals of its own modport.
`default_nettype none

interface sc_link_if;
  logic config_request_n;
  logic stat_dev_o;
  logic stat_dev_oe_n;
  logic stat_host_o;
  logic stat_host_oe_n;
  logic status_n;
  logic config_done;
  logic clk_host;
  logic clk_dev;
  logic config_clock;
  logic data_in_line;
  logic serial_out_line;
  logic as_mode;

  // ==========================================================
  // Wire resolution: status is open drain with a pull-up
  assign status_n     = (stat_dev_oe_n | stat_dev_o) & (stat_host_oe_n | stat_host_o);
  assign config_clock = as_mode ? clk_dev : clk_host;

  modport dev (
    input  config_request_n,
    input  status_n,
    input  config_clock,
    input  data_in_line,
    output stat_dev_o,
    output stat_dev_oe_n,
    output config_done,
    output clk_dev,
    output serial_out_line,
    output as_mode
  );

  modport host (
    input  status_n,
    input  config_done,
    input  config_clock,
    input  serial_out_line,
    input  as_mode,
    output config_request_n,
    output stat_host_o,
    output stat_host_oe_n,
    output clk_host,
    output data_in_line
  );
endinterface

`default_nettype wire

// ===== rtl/sc_cfg_device.sv
// Configured device end: reset handshake, serial intake, initialization.
// Assumes the host end keeps its own timing; all link pins are asynchronous.
`default_nettype none

module sc_cfg_device
  import sc_pkg::*;
#(
  parameter int CFG_BITS       = 64,
  parameter int STATUS_MIN_CYC = T_STATUS_MIN_US * SYS_MHZ,
  parameter int INIT_OSC_CYC   = T_CD2UM_MIN_US * SYS_MHZ
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  // Link
  sc_link_if.dev          link,
  // Mode and options
  input  wire logic       as_sel,
  input  wire logic       chain_mode,
  input  wire logic [1:0] osc_sel,
  input  wire logic       user_clk_opt,
  input  wire logic       user_init_clock,
  // Received stream and status
  output logic [7:0]      rx_byte,
  output logic            rx_valid,
  output logic            cfg_active,
  output logic            user_mode
);

  // ==========================================================
  // Input synchronisers
  localparam int NSYNC = 5;

  logic [NSYNC-1:0] raw;
  logic [NSYNC-1:0] s1_reg;
  logic [NSYNC-1:0] s2_reg;
  logic [NSYNC-1:0] s3_reg;
  logic [NSYNC-1:0] f_reg;
  logic [NSYNC-1:0] fd_reg;
  logic [NSYNC-1:0] f_next;

  assign raw = {user_init_clock, link.data_in_line, link.config_clock,
                link.status_n, link.config_request_n};

  // A change counts only once the second and third stages agree
  for (genvar i = 0; i < NSYNC; i++) begin : g_flt
    assign f_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : f_reg[i];
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      s1_reg <= DEV_SYNC_RST;
      s2_reg <= DEV_SYNC_RST;
      s3_reg <= DEV_SYNC_RST;
      f_reg  <= DEV_SYNC_RST;
      fd_reg <= DEV_SYNC_RST;
    end else begin
      s1_reg <= raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      f_reg  <= f_next;
      fd_reg <= f_reg;
    end
  end

  wire logic rq      = f_reg[0];
  wire logic st      = f_reg[1];
  wire logic dt      = f_reg[3];
  wire logic rq_fall = fd_reg[0] & ~f_reg[0];
  wire logic ck_rise = f_reg[2] & ~fd_reg[2];
  wire logic uc_rise = f_reg[4] & ~fd_reg[4];

  // ==========================================================
  // State and datapath registers
  sc_dev_state_e    state_reg;
  sc_dev_state_e    state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic [9:0]       ucnt_reg;
  logic [9:0]       ucnt_next;
  logic [CNT_W-1:0] bits_reg;
  logic [7:0]       sh_reg;
  logic [2:0]       div_reg;
  logic [3:0]       cmd_cnt_reg;
  logic             cclk_reg;
  logic             so_reg;
  logic             mode_reg;
  logic             done_reg;
  logic             stat_low_reg;
  logic             user_reg;

  // ==========================================================
  // Decode
  wire logic       in_cfg   = (state_reg == D_CFG);
  wire logic       as_run   = in_cfg && mode_reg;
  wire logic [1:0] eff_sel  = (chain_mode && osc_sel == OSC_100) ? OSC_50 : osc_sel;
  wire logic [2:0] half_m1  = 3'(sc_as_half(eff_sel) - 1);
  wire logic       div_end  = as_run && (div_reg == half_m1);
  wire logic       as_fall  = div_end && cclk_reg;
  wire logic       cmd_done = (cmd_cnt_reg == 4'(CMD_BITS));
  wire logic       cmd_bit  = AS_READ_CMD[~cmd_cnt_reg[2:0]];
  wire logic       cap      = in_cfg && (mode_reg ? (as_fall && cmd_done)
                                                  : ck_rise);
  wire logic [7:0] sh_next  = {dt, sh_reg[7:1]};
  wire logic       last_bit = (bits_reg == CNT_W'(CFG_BITS - 1));
  wire logic       hold_ok  = (cnt_reg >= CNT_W'(STATUS_MIN_CYC - 1));
  wire logic       uc_en    = (cnt_reg >= CNT_W'(CD2CU_CYC));
  wire logic       osc_done = (cnt_reg >= CNT_W'(INIT_OSC_CYC - 1));
  // The first counted edge only opens the first full user clock period
  wire logic       uc_done  = (ucnt_reg == 10'(INIT_MIN_CLKS + 1));
  wire logic       cfg_abort = in_cfg && !st;

  // ==========================================================
  // Sequence
  always_comb begin
    state_next = state_reg;
    cnt_next   = (&cnt_reg) ? cnt_reg : cnt_reg + 1'b1;
    ucnt_next  = ucnt_reg;
    case (state_reg)
      D_HOLD: begin
        // Status stays low while the request is held, and at least the minimum
        if (rq && hold_ok) begin
          state_next = D_WAIT;
        end
      end
      D_WAIT: begin
        // An external agent holding status low keeps us here
        if (st) begin
          state_next = D_CFG;
        end
      end
      D_CFG: begin
        if (cfg_abort) begin
          state_next = D_WAIT;
        end else if (cap && last_bit) begin
          state_next = D_INIT;
          cnt_next   = '0;
          ucnt_next  = '0;
        end
      end
      D_INIT: begin
        if (user_clk_opt) begin
          if (uc_en && uc_rise && !uc_done) begin
            ucnt_next = ucnt_reg + 1'b1;
          end
          if (uc_done) begin
            state_next = D_USER;
          end
        end else if (osc_done) begin
          state_next = D_USER;
        end
      end
      D_USER: begin
        state_next = D_USER;
      end
      default: begin
        state_next = D_HOLD;
      end
    endcase
    if (rq_fall) begin
      state_next = D_HOLD;
      cnt_next   = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_reg    <= D_HOLD;
      cnt_reg      <= '0;
      ucnt_reg     <= '0;
      mode_reg     <= 1'b0;
      done_reg     <= 1'b0;
      stat_low_reg <= 1'b1;
      user_reg     <= 1'b0;
    end else begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      ucnt_reg     <= ucnt_next;
      done_reg     <= (state_next == D_INIT) || (state_next == D_USER);
      stat_low_reg <= (state_next == D_HOLD);
      user_reg     <= (state_next == D_USER);
      if (state_reg == D_HOLD) begin
        mode_reg <= as_sel;
      end
    end
  end

  // ==========================================================
  // Active serial clock divider and command launch
  always_ff @(posedge sys_clk) begin
    if (!nrst || !as_run) begin
      div_reg     <= '0;
      cclk_reg    <= 1'b0;
      so_reg      <= 1'b0;
      cmd_cnt_reg <= '0;
    end else if (div_end) begin
      div_reg  <= '0;
      cclk_reg <= ~cclk_reg;
      if (cclk_reg && !cmd_done) begin
        so_reg      <= cmd_bit;
        cmd_cnt_reg <= cmd_cnt_reg + 1'b1;
      end
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  // ==========================================================
  // Bit intake, LSB first into bytes
  always_ff @(posedge sys_clk) begin
    if (!nrst || state_reg == D_HOLD || cfg_abort) begin
      sh_reg   <= '0;
      bits_reg <= '0;
      rx_byte  <= '0;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (cap) begin
        sh_reg   <= sh_next;
        bits_reg <= bits_reg + 1'b1;
        if (bits_reg[2:0] == BYTE_LAST) begin
          rx_byte  <= sh_next;
          rx_valid <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Outputs
  assign link.stat_dev_o      = 1'b0;
  assign link.stat_dev_oe_n   = ~stat_low_reg;
  assign link.config_done     = done_reg;
  assign link.clk_dev         = cclk_reg;
  assign link.serial_out_line = so_reg;
  assign link.as_mode         = mode_reg;
  assign cfg_active           = in_cfg;
  assign user_mode            = user_reg;

endmodule

`default_nettype wire

// ===== rtl/sc_cfg_host.sv
// Host end: request pulse, start-up wait, passive clocking or flash-style replies.
// Assumes the device end on the same link; bytes arrive from user logic via a FIFO.
`default_nettype none

module sc_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         sys_clk,
  input  wire logic         nrst,
  // Fill side
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  // Drain side
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D];
  logic [AW:0]  wp_reg;
  logic [AW:0]  rp_reg;

  wire logic full  = (wp_reg[AW] != rp_reg[AW]) && (wp_reg[AW-1:0] == rp_reg[AW-1:0]);
  wire logic empty = (wp_reg == rp_reg);
  wire logic push  = in_valid && !full;
  wire logic pop   = out_ready && !empty;

  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rp_reg[AW-1:0]];

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wp_reg[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      wp_reg <= '0;
      rp_reg <= '0;
    end else begin
      wp_reg <= wp_reg + (AW+1)'(push);
      rp_reg <= rp_reg + (AW+1)'(pop);
    end
  end
endmodule

module sc_cfg_host
  import sc_pkg::*;
#(
  parameter int CF2CK_CYC = T_CF2CK_US * SYS_MHZ
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  // Link
  sc_link_if.host         link,
  // Control
  input  wire logic       start,
  input  wire logic       mon_status,
  input  wire logic       hold_status,
  // Byte stream in
  input  wire logic [7:0] wr_data,
  input  wire logic       wr_valid,
  output logic            wr_ready,
  // Status
  output logic            busy,
  output logic            cfg_ok,
  output logic            cfg_err
);

  // ==========================================================
  // Input synchronisers
  logic [3:0] raw;
  logic [3:0] s1_reg;
  logic [3:0] s2_reg;
  logic [3:0] s3_reg;
  logic [3:0] f_reg;
  logic [3:0] fd_reg;
  logic [3:0] f_next;

  assign raw = {link.as_mode, link.config_clock, link.config_done, link.status_n};

  for (genvar i = 0; i < 4; i++) begin : g_flt
    assign f_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : f_reg[i];
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      s1_reg <= HOST_SYNC_RST;
      s2_reg <= HOST_SYNC_RST;
      s3_reg <= HOST_SYNC_RST;
      f_reg  <= HOST_SYNC_RST;
      fd_reg <= HOST_SYNC_RST;
    end else begin
      s1_reg <= raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      f_reg  <= f_next;
      fd_reg <= f_reg;
    end
  end

  wire logic st      = f_reg[0];
  wire logic dn      = f_reg[1];
  wire logic ck_fall = fd_reg[2] & ~f_reg[2];
  wire logic as_m    = f_reg[3];

  // ==========================================================
  // Registers and FIFO
  sc_host_state_e   state_reg;
  sc_host_state_e   state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic [2:0]       hcnt_reg;
  logic [2:0]       bcnt_reg;
  logic [3:0]       fcnt_reg;
  logic [7:0]       sh_reg;
  logic             hclk_reg;
  logic             bit_ok_reg;
  logic             have_reg;
  logic             dout_reg;
  logic             req_n_reg;
  logic             hold_reg;
  logic             ok_reg;
  logic             err_reg;
  logic [7:0]       f_data;
  logic             f_valid;
  logic             f_ready;

  sc_fifo #(.W(8), .D(8)) u_fifo (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .in_data   (wr_data),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (f_ready)
  );

  // ==========================================================
  // Decode
  wire logic sending  = (state_reg == H_SEND);
  wire logic ps_send  = sending && !as_m;
  wire logic half_end = (hcnt_reg == 3'(HOST_HALF_CYC - 1));
  // Passive clock stalls low while the FIFO is empty and no held byte is left to shift
  wire logic adv_ps   = ps_send && !hclk_reg && !bit_ok_reg && (have_reg || f_valid);
  // Replies run one fall ahead: both synchronisers together outlast one clock period
  wire logic adv_as   = sending && as_m && ck_fall && (fcnt_reg >= 4'(CMD_BITS - 2));
  wire logic adv      = adv_ps || adv_as;
  wire logic req_done = (cnt_reg >= CNT_W'(CFG_CYC - 1));
  wire logic mon_done = st && (cnt_reg >= CNT_W'(ST2CK_CYC - 1));
  wire logic blind_ok = (cnt_reg >= CNT_W'(CF2CK_CYC - 1));
  wire logic xfer_err = sending && mon_status && !hold_reg && !st && !dn;
  wire logic start_ok = start && (state_reg == H_IDLE || state_reg == H_DONE);

  assign f_ready = adv && !have_reg;

  // ==========================================================
  // Sequence
  always_comb begin
    state_next = state_reg;
    cnt_next   = (&cnt_reg) ? cnt_reg : cnt_reg + 1'b1;
    case (state_reg)
      H_IDLE, H_DONE: begin
        if (start) begin
          state_next = H_REQ;
          cnt_next   = '0;
        end
      end
      H_REQ: begin
        if (req_done) begin
          state_next = H_WAIT;
          cnt_next   = '0;
        end
      end
      H_WAIT: begin
        if (mon_status && !st) begin
          cnt_next = '0;
        end
        // A flash has no start-up wait: it follows the device clock once status is up
        if (as_m ? st : (mon_status ? mon_done : blind_ok)) begin
          state_next = H_SEND;
        end
      end
      H_SEND: begin
        if (dn) begin
          state_next = H_DONE;
        end else if (xfer_err) begin
          state_next = H_REQ;
          cnt_next   = '0;
        end
      end
      default: begin
        state_next = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_reg <= H_IDLE;
      cnt_reg   <= '0;
      req_n_reg <= 1'b1;
      hold_reg  <= 1'b0;
      ok_reg    <= 1'b0;
      err_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      req_n_reg <= (state_next != H_REQ);
      hold_reg  <= hold_status;
      ok_reg    <= (state_next == H_DONE);
      // Error capture wins over the clear by a new start
      err_reg   <= xfer_err || (err_reg && !start_ok);
    end
  end

  // ==========================================================
  // Passive clock: data settles in the low half, then the rising edge
  always_ff @(posedge sys_clk) begin
    if (!nrst || !ps_send) begin
      hclk_reg   <= 1'b0;
      hcnt_reg   <= '0;
      bit_ok_reg <= 1'b0;
    end else if (adv_ps) begin
      bit_ok_reg <= 1'b1;
      hcnt_reg   <= '0;
    end else if (bit_ok_reg) begin
      if (half_end) begin
        hcnt_reg <= '0;
        hclk_reg <= ~hclk_reg;
        if (hclk_reg) begin
          bit_ok_reg <= 1'b0;
        end
      end else begin
        hcnt_reg <= hcnt_reg + 1'b1;
      end
    end
  end

  // ==========================================================
  // Bit stream, LSB first; in active mode it follows the command bits
  always_ff @(posedge sys_clk) begin
    if (!nrst || !sending) begin
      sh_reg   <= '0;
      bcnt_reg <= '0;
      have_reg <= 1'b0;
      dout_reg <= 1'b0;
      fcnt_reg <= '0;
    end else begin
      if (ck_fall && fcnt_reg != 4'(CMD_BITS)) begin
        fcnt_reg <= fcnt_reg + 1'b1;
      end
      if (adv) begin
        if (have_reg) begin
          dout_reg <= sh_reg[0];
          sh_reg   <= {1'b0, sh_reg[7:1]};
          bcnt_reg <= bcnt_reg + 1'b1;
          if (bcnt_reg == BYTE_LAST) begin
            have_reg <= 1'b0;
          end
        end else if (f_valid) begin
          dout_reg <= f_data[0];
          sh_reg   <= {1'b0, f_data[7:1]};
          bcnt_reg <= 3'h1;
          have_reg <= 1'b1;
        end else begin
          dout_reg <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // Outputs
  assign link.config_request_n = req_n_reg;
  assign link.stat_host_o      = 1'b0;
  assign link.stat_host_oe_n   = ~hold_reg;
  assign link.clk_host         = hclk_reg;
  assign link.data_in_line     = dout_reg;
  assign busy                  = !(state_reg == H_IDLE || state_reg == H_DONE);
  assign cfg_ok                = ok_reg;
  assign cfg_err               = err_reg;

endmodule

`default_nettype wire

// ===== dv/sc_link_props.sv
// Checker for the link between the host end and the device end.
// Assumes one instance beside the link, fed the link's own signals.
`default_nettype none

module sc_link_props
  import sc_pkg::*;
#(
  parameter int STATUS_MIN_CYC = 40,
  parameter int CF2CK_CYC      = 300
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Link
  input wire logic config_request_n,
  input wire logic status_n,
  input wire logic stat_dev_oe_n,
  input wire logic config_done,
  input wire logic config_clock,
  input wire logic data_in_line,
  input wire logic serial_out_line,
  input wire logic as_mode
);
  localparam int REL_LIM = 300;

  logic        req_q_reg;
  logic [15:0] lo_cnt_reg;
  logic [15:0] fall_cnt_reg;
  logic [15:0] rise_cnt_reg;
  logic [15:0] sthi_cnt_reg;

  // ==========================================================
  // Cycle counters; 16 bits suffice since a run never wraps them
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      req_q_reg    <= 1'b1;
      lo_cnt_reg   <= 16'h0;
      fall_cnt_reg <= 16'h0;
      rise_cnt_reg <= 16'h0;
      sthi_cnt_reg <= 16'h0;
    end else begin
      req_q_reg    <= config_request_n;
      lo_cnt_reg   <= config_request_n ? 16'h0 : lo_cnt_reg + 16'h1;
      fall_cnt_reg <= (req_q_reg && !config_request_n) ? 16'h0 : fall_cnt_reg + 16'h1;
      rise_cnt_reg <= config_request_n ? rise_cnt_reg + 16'h1 : 16'h0;
      sthi_cnt_reg <= status_n ? sthi_cnt_reg + 16'h1 : 16'h0;
    end
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence s_cleared;
    !status_n && !config_done;
  endsequence
  sequence s_as_rise;
    $rose(config_clock) && as_mode;
  endsequence
  sequence s_ps_rise;
    $rose(config_clock) && !as_mode;
  endsequence

  req_low_width_a: assert property (
    $rose(config_request_n) |-> lo_cnt_reg >= CFG_CYC)
    else $error("request pulse too short");
  done_status_fall_a: assert property (
    $fell(config_request_n) |-> ##[1:60] s_cleared)
    else $error("done or status not low after request");
  hold_done_low_a: assert property (
    !stat_dev_oe_n |-> ##1 !config_done)
    else $error("done high while device holds status");
  status_min_a: assert property (
    $rose(stat_dev_oe_n) |-> fall_cnt_reg >= STATUS_MIN_CYC)
    else $error("status released too early");
  status_release_a: assert property (
    $rose(config_request_n) |-> ##[0:REL_LIM] stat_dev_oe_n)
    else $error("status not released");
  clk_start_wait_a: assert property (
    s_ps_rise |-> (rise_cnt_reg >= CF2CK_CYC || sthi_cnt_reg >= ST2CK_CYC))
    else $error("first clock rise too early");
  ps_data_stable_a: assert property (
    s_ps_rise |-> $stable(data_in_line))
    else $error("data moved at rising clock");
  as_launch_fall_a: assert property (
    as_mode && $changed(serial_out_line) |-> !config_clock)
    else $error("serial out moved while clock high");
  as_clk_high_a: assert property (
    s_as_rise |-> ##[1:4] !config_clock)
    else $error("active clock high phase too long");
endmodule

`default_nettype wire

// ===== dv/tb_serial_config_sequence.sv
// Bench joining the host end and the device end over one link.
// Assumes the design under rtl/ and the link checker under dv/.
`default_nettype none

module tb_serial_config_sequence
  import sc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic       sys_clk, nrst, as_sel, chain_mode, user_clk_opt, user_init_clock;
  logic       start, mon_status, wr_valid, rx_valid, cfg_active, user_mode, hold_status;
  logic       wr_ready, busy, cfg_ok, cfg_err, clk_q;
  logic [1:0] osc_sel;
  logic [7:0] wr_data, rx_byte, cmd;
  logic [7:0] rxq[$];
  int         err_count, cmp_count, cyc, hi, last_hi, nf;

  sc_link_if u_sc_link_if ();
  sc_cfg_device #(.STATUS_MIN_CYC(40), .INIT_OSC_CYC(30)) u_sc_cfg_device (
    .sys_clk, .nrst, .link(u_sc_link_if), .as_sel, .chain_mode, .osc_sel, .user_clk_opt,
    .user_init_clock, .rx_byte, .rx_valid, .cfg_active, .user_mode);
  sc_cfg_host #(.CF2CK_CYC(300)) u_sc_cfg_host (
    .sys_clk, .nrst, .link(u_sc_link_if), .start, .mon_status, .hold_status,
    .wr_data, .wr_valid, .wr_ready, .busy, .cfg_ok, .cfg_err);
  sc_link_props #(.STATUS_MIN_CYC(40), .CF2CK_CYC(300)) u_sc_link_props (
    .sys_clk, .nrst, .config_request_n(u_sc_link_if.config_request_n),
    .status_n(u_sc_link_if.status_n), .stat_dev_oe_n(u_sc_link_if.stat_dev_oe_n),
    .config_done(u_sc_link_if.config_done), .config_clock(u_sc_link_if.config_clock),
    .data_in_line(u_sc_link_if.data_in_line), .as_mode(u_sc_link_if.as_mode),
    .serial_out_line(u_sc_link_if.serial_out_line));

  // ==========================================================
  // Clocks: user init clock at 80 ns, unrelated to sys_clk
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    user_init_clock = 1'b0;
    #13;
    // Not shared with calibration, so it need not run at exactly 100 MHz
    forever #40 user_init_clock = ~user_init_clock;
  end

  // ==========================================================
  // Link monitor: bytes, high phase length, first eight launched bits
  always @(posedge sys_clk) begin
    cyc++;
    if (rx_valid === 1'b1) rxq.push_back(rx_byte);
    if (u_sc_link_if.config_clock === 1'b1) hi++;
    else if (clk_q === 1'b1) begin
      last_hi = hi;
      hi = 0;
      if (nf < 8) cmd = {cmd[6:0], u_sc_link_if.serial_out_line};
      nf++;
    end
    clk_q = u_sc_link_if.config_clock;
    if (cyc == 30000) begin
      err_count++;
      close_out();
    end
  end

  function automatic logic [7:0] pat(input int k);
    return 8'h5A + 8'h13 * k[7:0];
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
    end
  endtask

  // ==========================================================
  // One full configuration: fill buffer, start, wait done and user mode
  task automatic run(input logic as, input logic mon, input logic uc, input logic [1:0] sel,
                     input int half, input int lo, input int hi_lim);
    int n;
    nrst = 1'b0;
    as_sel = as;
    mon_status = mon;
    user_clk_opt = uc;
    osc_sel = sel;
    repeat (3) @(posedge sys_clk);
    #1 nrst = 1'b1;
    rxq = {};
    nf = 0;
    hi = 0;
    for (int i = 0; i < 8; i++) begin
      wr_data = pat(i);
      wr_valid = 1'b1;
      @(posedge sys_clk);
      #1;
    end
    wr_valid = 1'b0;
    chk(wr_ready, 1'b0);
    start = 1'b1;
    @(posedge sys_clk);
    #1 start = 1'b0;
    if (mon) begin
      // Status held low by the host keeps the device waiting
      hold_status = 1'b1;
      repeat (400) @(posedge sys_clk);
      #1;
      chk(cfg_active, 1'b0);
      chk(busy, 1'b1);
      hold_status = 1'b0;
    end
    n = 0;
    while (u_sc_link_if.config_done !== 1'b1 && n < 5000) begin
      @(posedge sys_clk);
      #1 n++;
    end
    chk(u_sc_link_if.config_done, 1'b1);
    n = 0;
    while (user_mode !== 1'b1 && n < 6000) begin
      @(posedge sys_clk);
      #1 n++;
    end
    chk(n >= lo && n <= hi_lim, 1'b1);
    chk({busy, cfg_ok, cfg_err}, 3'h2);
    chk(last_hi, half);
    if (as) chk(cmd, AS_READ_CMD);
    if (sel == 2'h0) begin
      chk(wr_ready, 1'b1);
      chk(rxq.size(), 8);
      foreach (rxq[k]) chk(rxq[k], pat(k));
    end
    $display("test end as=%0b sel=%0d user_clk=%0b", as, sel, uc);
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    nrst = 1'b0;
    as_sel = 1'b0;
    chain_mode = 1'b0;
    osc_sel = 2'h0;
    user_clk_opt = 1'b0;
    start = 1'b0;
    mon_status = 1'b0;
    hold_status = 1'b0;
    wr_valid = 1'b0;
    wr_data = 8'h00;
    clk_q = 1'b0;
    cmd = 8'h00;
    err_count = 0;
    cmp_count = 0;
    cyc = 0;
    @(posedge sys_clk);
    #1;
    run(1'b0, 1'b1, 1'b0, 2'h0, 4, 30, 142);
    run(1'b0, 1'b0, 1'b0, 2'h0, 4, 30, 142);
    run(1'b1, 1'b0, 1'b1, 2'h0, 4, 4804, 4830);
    for (int s = 1; s < 4; s++) run(1'b1, 1'b0, 1'b0, s[1:0], (s == 1) ? 2 : 1, 30, 142);
    chain_mode = 1'b1;
    run(1'b1, 1'b0, 1'b0, 2'h3, 1, 30, 142);
    close_out();
  end
endmodule

`default_nettype wire
